// ==== design/lsp_pkg.sv ====
// Constants, field positions and state encodings for the loop station
package lsp_pkg;
    // Loop configuration bit positions
    localparam int CFG_LOOP_MODE_BIT = 1;
    localparam int CFG_ABORT_UNDERRUN_BIT = 2;
    localparam int CFG_FLAG_IDLE_BIT = 3;
    localparam int CFG_GO_ACTIVE_BIT = 4;
    // Loop status bit positions
    localparam int STS_ON_LOOP_BIT = 1;
    localparam int STS_LOOP_SENDING_BIT = 4;
    // Patterns as an 8-bit window (SEVEN_ONES on its low 7 bits), oldest bit in bit 7, newest in bit 0
    localparam logic [7:0] FLAG_PATTERN = 8'h7e;
    localparam logic [7:0] END_OF_POLL_WINDOW = 8'h7f;
    localparam logic [6:0] SEVEN_ONES = 7'h7f;
    // Serializer counts
    localparam logic [2:0] ZERO_INSERT_RUN = 3'h5;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;
    // Transmit data buffer
    localparam int DATA_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_GATE = 3'b001,
        ST_SEEK = 3'b010,
        ST_HUNT = 3'b011,
        ST_ARMED = 3'b100,
        ST_SEND = 3'b101
    } lsp_state_t;
endpackage

// ==== design/lsp_fifo_if.sv ====
// Valid/ready carrier between the loop station and its transmit FIFO
`timescale 1ns/1ps
interface lsp_fifo_if #(parameter int W = 8);
    logic [W-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [W-1:0] rdata;
    logic rvalid;
    logic rready;
    modport fifo_side (input wdata, input wvalid, input rready, output wready, output rdata, output rvalid);
    modport user (output wdata, output wvalid, output rready, input wready, input rdata, input rvalid);
endinterface

// ==== design/lsp_fifo.sv ====
// Flip-flop FIFO for transmit bytes with valid/ready on both sides
`timescale 1ns/1ps
module lsp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    lsp_fifo_if.fifo_side fq
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [CW-1:0] cnt;
    } lsp_fifo_st_t;

    lsp_fifo_st_t r;
    lsp_fifo_st_t next_r;
    logic push;
    logic pop;

    assign fq.wready = (r.cnt != FULL_CNT);
    assign fq.rvalid = (r.cnt != '0);
    assign fq.rdata = r.mem[r.rptr];
    assign push = fq.wvalid && fq.wready;
    assign pop = fq.rready && fq.rvalid;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wptr] = fq.wdata;
            next_r.wptr = (r.wptr == LAST_PTR) ? '0 : r.wptr + 1'b1;
        end
        if (pop) begin
            next_r.rptr = (r.rptr == LAST_PTR) ? '0 : r.rptr + 1'b1;
        end
        if (push && !pop) begin
            next_r.cnt = r.cnt + 1'b1;
        end else if (pop && !push) begin
            next_r.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    default clocking fifo_cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    fifo_no_overflow_a: assert property (r.cnt <= FULL_CNT)
        else $error("FIFO count exceeds depth");
    fifo_count_step_a: assert property (push && !pop |=> r.cnt == $past(r.cnt) + 1'b1)
        else $error("FIFO count did not rise on push");
    fifo_fill_c: cover property (r.cnt == FULL_CNT);
endmodule // lsp_fifo

// ==== design/lsp_loop_station.sv ====
// Secondary-station SDLC loop control: relay, poll conversion, own frames
`timescale 1ns/1ps
module lsp_loop_station (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic rxd_in,
    input wire logic bit_tick_in,
    output logic txd_out,
    input wire logic [7:0] loop_config_reg_in,
    output logic [7:0] loop_status_reg_out,
    output logic break_abort_out,
    input wire logic break_abort_clr_in,
    output logic hunt_out,
    input wire logic ext_irq_en_in,
    output logic ext_irq_out,
    input wire logic [lsp_pkg::DATA_WIDTH-1:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    import lsp_pkg::*;

    typedef struct packed {
        lsp_state_t st;
        logic [6:0] hist;
        logic dly;
        logic [7:0] sh;
        logic [2:0] bcnt;
        logic [2:0] ones;
        logic sh_data;
        logic closing;
        logic fin;
        logic leaving;
        logic txbit;
        logic on_loop;
        logic sending;
        logic brk;
        logic hunt_off;
        logic irq;
    } lsp_core_t;

    lsp_core_t r;
    lsp_core_t next_r;
    logic [7:0] win;
    logic loop_mode;
    logic go_active;
    logic flag_idle;
    logic seen_eop;
    logic seen_flag;
    logic seen_ones;
    logic brk_set;
    logic pop;

    lsp_fifo_if #(.W(DATA_WIDTH)) fq ();

    lsp_fifo #(
        .W(DATA_WIDTH),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .fq(fq.fifo_side)
    );

    assign fq.wdata = tx_data_in;
    assign fq.wvalid = tx_valid_in;
    assign fq.rready = pop;
    assign tx_ready_out = fq.wready;

    ////////////////////////////////////////////////////////////////////////
    // Pattern watch on the raw line, ahead of any zero deletion
    assign win = {r.hist, rxd_in};
    assign seen_eop = bit_tick_in && (win == END_OF_POLL_WINDOW);
    assign seen_flag = bit_tick_in && (win == FLAG_PATTERN);
    assign seen_ones = bit_tick_in && (win[6:0] == SEVEN_ONES);
    assign loop_mode = loop_config_reg_in[CFG_LOOP_MODE_BIT];
    assign go_active = loop_config_reg_in[CFG_GO_ACTIVE_BIT];
    // Only the off-loop idle choice is honoured; in loop mode both idle and underrun settings are moot
    assign flag_idle = loop_config_reg_in[CFG_FLAG_IDLE_BIT] && (r.st == ST_OFF);

    ////////////////////////////////////////////////////////////////////////
    // Line output: a pure gate path must stay combinational
    always_comb begin
        case (r.st)
            ST_GATE, ST_SEEK: txd_out = rxd_in;
            ST_HUNT, ST_ARMED: txd_out = r.dly;
            default: txd_out = r.txbit;
        endcase
    end

    always_comb begin
        loop_status_reg_out = 8'h00;
        loop_status_reg_out[STS_ON_LOOP_BIT] = r.on_loop;
        loop_status_reg_out[STS_LOOP_SENDING_BIT] = r.sending;
    end

    assign break_abort_out = r.brk;
    assign hunt_out = (r.st == ST_HUNT) || r.hunt_off;
    assign ext_irq_out = r.irq;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_r = r;
        brk_set = 1'b0;
        pop = 1'b0;
        if (bit_tick_in) begin
            next_r.hist = win[6:0];
            next_r.dly = rxd_in;
        end
        case (r.st)
            ST_OFF: begin
                if (bit_tick_in) begin
                    next_r.txbit = flag_idle ? r.sh[r.bcnt] : 1'b1;
                    next_r.bcnt = r.bcnt + 1'b1;
                end
                if (loop_mode) begin
                    next_r.st = ST_GATE;
                    next_r.sh = FLAG_PATTERN;
                    next_r.bcnt = '0;
                    next_r.hunt_off = 1'b0;
                    next_r.leaving = 1'b0;
                end
            end
            ST_GATE: begin
                if (!loop_mode) begin
                    next_r.st = ST_OFF;
                end else if (go_active) begin
                    next_r.st = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (!loop_mode) begin
                    next_r.st = ST_OFF;
                end else if (seen_ones) begin
                    next_r.st = ST_HUNT;
                    next_r.on_loop = 1'b1;
                    brk_set = 1'b1;
                end
            end
            ST_HUNT: begin
                if (seen_flag) begin
                    // A flag must end hunt before the station may send or leave
                    if (!loop_mode) begin
                        next_r.st = ST_OFF;
                        next_r.on_loop = 1'b0;
                        next_r.hunt_off = 1'b1;
                    end else begin
                        next_r.st = ST_ARMED;
                    end
                end
            end
            ST_ARMED: begin
                if (seen_eop && !loop_mode) begin
                    next_r.st = ST_OFF;
                    next_r.on_loop = 1'b0;
                    next_r.hunt_off = 1'b1;
                    next_r.txbit = 1'b1;
                    brk_set = 1'b1;
                end else if (seen_eop && go_active) begin
                    // Last one of the poll becomes the final zero of a flag
                    next_r.st = ST_SEND;
                    next_r.txbit = 1'b0;
                    next_r.sending = 1'b1;
                    next_r.sh = FLAG_PATTERN;
                    next_r.sh_data = 1'b0;
                    next_r.bcnt = '0;
                    next_r.ones = '0;
                    next_r.closing = 1'b0;
                    next_r.fin = 1'b0;
                    next_r.leaving = 1'b0;
                    brk_set = 1'b1;
                end
            end
            ST_SEND: begin
                if (!loop_mode) begin
                    next_r.leaving = 1'b1;
                end
                if (bit_tick_in) begin
                    if (r.fin) begin
                        // Closing flag is fully on the line now
                        next_r.sending = 1'b0;
                        next_r.fin = 1'b0;
                        next_r.txbit = 1'b1;
                        if (r.leaving || !loop_mode) begin
                            next_r.st = ST_OFF;
                            next_r.on_loop = 1'b0;
                        end else begin
                            next_r.st = ST_ARMED;
                        end
                    end else if (r.ones == ZERO_INSERT_RUN) begin
                        next_r.txbit = 1'b0;
                        next_r.ones = '0;
                    end else begin
                        next_r.txbit = r.sh[0];
                        next_r.ones = (r.sh_data && r.sh[0]) ? r.ones + 1'b1 : 3'h0;
                        next_r.sh = {1'b0, r.sh[7:1]};
                        next_r.bcnt = r.bcnt + 1'b1;
                        if (r.bcnt == LAST_BIT_INDEX) begin
                            // The run of data ones carries on, so a zero is stuffed across byte edges too
                            next_r.sh_data = 1'b0;
                            next_r.sh = FLAG_PATTERN;
                            if (r.closing) begin
                                next_r.fin = 1'b1;
                            end else if (fq.rvalid) begin
                                pop = 1'b1;
                                next_r.sh = fq.rdata;
                                next_r.sh_data = 1'b1;
                            end else if (go_active && !r.leaving && loop_mode) begin
                                next_r.closing = 1'b0;
                            end else begin
                                next_r.closing = 1'b1;
                            end
                        end
                    end
                end
            end
            default: next_r.st = ST_OFF;
        endcase
        // A new break event outranks a clear in the same cycle
        next_r.brk = (r.brk && !break_abort_clr_in) || brk_set;
        next_r.irq = brk_set && !r.brk && ext_irq_en_in;
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking core_cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    gate_relay_a: assert property ((r.st == ST_GATE || r.st == ST_SEEK) |-> txd_out == rxd_in)
        else $error("Gate relay path broken");
    go_on_loop_a: assert property (r.st == ST_SEEK && loop_mode && seen_ones
        |=> r.st == ST_HUNT && r.on_loop && r.brk && loop_status_reg_out[1])
        else $error("Seven ones did not put station on loop");
    // The converting tick is left to poll_convert_a: there the last one is replaced on purpose
    delay_relay_a: assert property (r.st == ST_ARMED && bit_tick_in
        && !(seen_eop && go_active && loop_mode) |=> txd_out == $past(rxd_in))
        else $error("Relay is not one bit late");
    hunt_no_send_a: assert property (r.st == ST_HUNT |=> r.st != ST_SEND)
        else $error("Sending straight out of hunt");
    poll_convert_a: assert property (r.st == ST_ARMED && seen_eop && go_active && loop_mode
        |=> txd_out == 1'b0 && loop_status_reg_out[4] ##1 r.st == ST_SEND)
        else $error("End of poll not turned into flag");
    zero_insert_a: assert property (r.st == ST_SEND && bit_tick_in && !r.fin && r.sh_data
        && r.ones == ZERO_INSERT_RUN |=> txd_out == 1'b0 && r.ones == 3'h0)
        else $error("Zero not inserted after five ones");
    sending_clear_a: assert property (r.st == ST_SEND && r.fin && bit_tick_in
        |=> !r.sending && (r.st == ST_ARMED || r.st == ST_OFF))
        else $error("Loop sending not cleared after closing flag");
    quick_exit_a: assert property (r.st == ST_GATE && !loop_mode |=> r.st == ST_OFF && !r.on_loop)
        else $error("Idle station did not disconnect at once");
    poll_exit_a: assert property (r.st == ST_ARMED && seen_eop && !loop_mode
        |=> r.st == ST_OFF && r.brk && hunt_out && !loop_status_reg_out[1])
        else $error("Leaving on end of poll mis-flagged");
    brk_set_wins_a: assert property (brk_set && break_abort_clr_in |=> break_abort_out)
        else $error("Break event lost against clear");
    // Interrupt, echo, hunt and status checks
    irq_one_cycle_a: assert property (ext_irq_out |=> !ext_irq_out)
        else $error("Interrupt pulse longer than one cycle");
    hunt_hold_a: assert property (r.st == ST_HUNT && !seen_flag |=> r.st == ST_HUNT)
        else $error("Hunt left without a flag");
    hunt_echo_a: assert property (r.st == ST_HUNT && bit_tick_in && !seen_flag
        |=> txd_out == $past(rxd_in))
        else $error("Hunting station does not echo one bit late");
    off_status_a: assert property (r.st == ST_OFF |-> !r.on_loop && !loop_status_reg_out[4])
        else $error("Status left set off the loop");
    send_status_a: assert property (r.st == ST_SEND |-> loop_status_reg_out[4])
        else $error("Loop sending low while sending");

    on_loop_c: cover property (r.st == ST_HUNT ##1 r.st == ST_ARMED);
    poll_flag_c: cover property (r.st == ST_ARMED ##1 r.st == ST_SEND);
    send_frame_c: cover property (r.st == ST_SEND && pop);
    leave_loop_c: cover property (r.st == ST_ARMED && seen_eop && !loop_mode);
endmodule // lsp_loop_station

// ==== bench/lsp_loop_partner.sv ====
// Loop line model: upstream bits with a bit clock that runs only while bits are queued
`timescale 1ns/1ps
module lsp_loop_partner (
    input wire logic mclk_in,
    input wire logic txd_in,
    output logic rxd_out,
    output logic bit_tick_out
);
    logic bits_q[$];
    logic seen_q[$];
    logic [1:0] phase = 2'h0;

    initial begin
        rxd_out = 1'b1;
        bit_tick_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Four cycles a bit; the line taken back in the tick cycle, where it has settled
    always @(negedge mclk_in) begin
        bit_tick_out <= (bits_q.size() != 0) && (phase == 2'h2);
        if (bits_q.size() == 0) begin
            rxd_out <= 1'b1; // Loop line marks idle when nothing is sent
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h0) begin
                rxd_out <= bits_q[0];
            end
            if (phase == 2'h2) begin
                // Taken before the tick edge, as the next station down the loop would see it
                seen_q.push_back(txd_in);
            end
            if (phase == 2'h3) begin
                void'(bits_q.pop_front());
            end
        end
    end
endmodule // lsp_loop_partner

// ==== bench/lsp_loop_station_bench.sv ====
// Self-checking bench for the loop station: line rows, then frame, exit and reset cases
`timescale 1ns/1ps
module lsp_loop_station_bench;
    import lsp_pkg::*;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rx;
        logic [7:0] tx;
        logic [7:0] sts;
        logic hunt;
        logic brk;
        logic chkb;
        logic ien;
    } lsp_row_t;

    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic rxd, tick, txd, brk, hunt, irq, rdy;
    logic [7:0] cfg = 8'h00;
    logic [7:0] sts;
    logic brk_clr = 1'b0;
    logic ien = 1'b0;
    logic [7:0] txb = 8'h00;
    logic txv = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int n_irq = 0;
    logic [7:0] data [8] = '{8'h1f, 8'ha5, 8'hff, 8'h00, 8'h3e, 8'h81, 8'h7e, 8'hf8};
    // cfg, line in, line out, status, hunt, break, check break, irq enable
    lsp_row_t rows [8] = '{
        '{8'h02, 8'h55, 8'h55, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
        '{8'h12, 8'h7f, 8'h7f, 8'h02, 1'b1, 1'b1, 1'b1, 1'b1},
        '{8'h00, 8'hff, 8'hff, 8'h02, 1'b1, 1'b0, 1'b1, 1'b1},
        '{8'h00, 8'h7e, 8'hbf, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1},
        '{8'h02, 8'h55, 8'h55, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
        '{8'h12, 8'h7f, 8'h7f, 8'h02, 1'b1, 1'b1, 1'b1, 1'b0},
        '{8'h12, 8'h7e, 8'hbf, 8'h02, 1'b0, 1'b0, 1'b1, 1'b0},
        '{8'h02, 8'h7f, 8'h3f, 8'h02, 1'b0, 1'b0, 1'b0, 1'b0}
    };

    always #25 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        if (irq === 1'b1) begin
            n_irq <= n_irq + 1;
        end
    end

    lsp_loop_station u_lsp_loop_station (.mclk_in(mclk_in), .nrst_in(nrst_in), .rxd_in(rxd), .bit_tick_in(tick),
        .txd_out(txd), .loop_config_reg_in(cfg), .loop_status_reg_out(sts), .break_abort_out(brk),
        .break_abort_clr_in(brk_clr), .hunt_out(hunt), .ext_irq_en_in(ien), .ext_irq_out(irq),
        .tx_data_in(txb), .tx_valid_in(txv), .tx_ready_out(rdy));
    lsp_loop_partner u_lsp_loop_partner (.mclk_in(mclk_in), .txd_in(txd), .rxd_out(rxd), .bit_tick_out(tick));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // n of 8 sends b oldest bit first; any other n sends marking ones
    task automatic feed(input logic [7:0] b, input int n);
        int t;
        for (int i = 0; i < n; i++) begin
            u_lsp_loop_partner.bits_q.push_back(n == 8 ? b[7 - i] : 1'b1);
        end
        t = 0;
        while (u_lsp_loop_partner.bits_q.size() != 0 && t < 8 * n) begin
            cyc(1);
            t++;
        end
        cyc(3);
    endtask

    task automatic send(input logic [7:0] b, output logic [7:0] seen);
        u_lsp_loop_partner.seen_q.delete();
        feed(b, 8);
        for (int i = 0; i < 8; i++) begin
            seen[7 - i] = u_lsp_loop_partner.seen_q[i];
        end
    endtask

    // Valid stays up between calls, so back-to-back writes never toggle it within one step
    task automatic wr(input logic [7:0] b, output logic took);
        txb = b;
        txv = 1'b1;
        took = rdy;
        cyc(1);
    endtask

    task automatic clr_break();
        brk_clr = 1'b1;
        cyc(1);
        brk_clr = 1'b0;
    endtask

    task automatic do_reset(input int n);
        nrst_in = 1'b0;
        cyc(n);
        nrst_in = 1'b1;
        cyc(2);
        chk("status after reset", sts, 8'h00);
        chk("break after reset", brk, 1'b0);
        chk("hunt after reset", hunt, 1'b0);
        chk("ready after reset", rdy, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk_in);
        n_fail++;
        final_report();
    end

    initial begin
        logic [7:0] seen;
        logic took;
        logic exp_q[$];
        int k;
        int nf;
        int bad;
        int run;
        do_reset(20);
        // Frame queued before going on loop must stay unsent until polled
        foreach (data[i]) begin
            wr(data[i], took);
            chk("fifo accepts", took, 1'b1);
        end
        wr(8'h99, took);
        chk("fifo full refuses", took, 1'b0);
        txv = 1'b0;
        foreach (rows[i]) begin
            cfg = rows[i].cfg;
            ien = rows[i].ien;
            n_irq = 0;
            send(rows[i].rx, seen);
            chk("line out", seen, rows[i].tx);
            chk("loop status", sts, rows[i].sts);
            chk("hunt", hunt, rows[i].hunt);
            if (rows[i].chkb) begin
                chk("break", brk, rows[i].brk);
                chk("irq pulses", n_irq, rows[i].brk & rows[i].ien);
            end
            clr_break();
        end
        // Poll with the unused idle and underrun options set on purpose
        cfg = 8'h1e;
        send(8'h7f, seen);
        chk("relay of poll", seen, 8'hbf);
        chk("sending status", sts, 8'h12);
        u_lsp_loop_partner.seen_q.delete();
        feed(8'h00, 100);
        cfg = 8'h0e;
        feed(8'h00, 40);
        exp_q = {1'b0};
        for (int j = 0; j < 8; j++) begin
            exp_q.push_back(FLAG_PATTERN[7 - j]);
        end
        run = 0;
        foreach (data[i]) begin
            for (int j = 0; j < 8; j++) begin
                exp_q.push_back(data[i][j]);
                run = data[i][j] ? run + 1 : 0;
                if (run == 5) begin
                    exp_q.push_back(1'b0);
                    run = 0;
                end
            end
        end
        bad = 0;
        foreach (exp_q[i]) begin
            if (u_lsp_loop_partner.seen_q[i] !== exp_q[i]) begin
                bad++;
            end
        end
        chk("frame bits", bad, 0);
        k = exp_q.size();
        nf = 0;
        while (k + 8 <= u_lsp_loop_partner.seen_q.size() && u_lsp_loop_partner.seen_q[k] === 1'b0) begin
            for (int j = 0; j < 8; j++) begin
                if (u_lsp_loop_partner.seen_q[k + j] !== FLAG_PATTERN[7 - j]) begin
                    bad++;
                end
            end
            nf++;
            k += 8;
        end
        chk("flag bits", bad, 0);
        chk("several flags", nf > 1, 1'b1);
        chk("relay after close", u_lsp_loop_partner.seen_q[k], 1'b1);
        chk("sending cleared", sts, 8'h02);
        chk("fifo drained", rdy, 1'b1);
        // Leave only after sending ended, with mark idle
        cfg = 8'h00;
        ien = 1'b1;
        clr_break();
        n_irq = 0;
        send(8'h55, seen);
        chk("delay kept", seen, 8'haa);
        chk("still on loop", sts, 8'h02);
        send(8'h7f, seen);
        chk("off loop status", sts, 8'h00);
        chk("break on exit", brk, 1'b1);
        chk("hunt on exit", hunt, 1'b1);
        chk("irq on exit", n_irq, 1);
        send(8'h55, seen);
        chk("marking off loop", seen, 8'hff);
        do_reset(2);
        final_report();
    end
endmodule // lsp_loop_station_bench
